// file: cbs_defines.vh
// What this block does
// - a cell with timer zero is never balanced in the cycle started next
// - start command samples all configuration; later changes ignored until next start
// - running flag holds through whole cycle incl. hold; clears when complete sets
// - duty zero: cell done on timer expiry or voltage; switch off, others continue
// - non-duty: first bank finishes, then second bank if selected, then complete
// - zero-timer cell in a selected bank gets done bit right after start
// - single bank order: only that bank's done bits update; others cleared at start
// - nonzero duty with two-bank order: bank-switch timer alternates banks each period until all done
// - duty mode: a finished bank is skipped, stay on unfinished bank
// - hold freezes machine and timers, switches off, hold status set
// - faults ignored while held; policy applied on release if fault remains
// - manual apply turns on selected cells unless two adjacent cells are chosen
// - manual apply ignored while running unless held; latched on rising edge when not running or held
// - switch-check enable gates comparator flag; flag valid within 2.5 ms
// - low-cell flag reported; host treats switch check result as invalid
// - open-wire sinks on pins 1-6 and source on pin 0 enabled by control
// - cell timer accepts 0 (no balancing) up to 127 units
// - abort on fault set: unmasked fault ends balancing, aborted flag set
`ifndef CBS_DEFINES_VH
`define CBS_DEFINES_VH
`define CBS_SEQ_ODD_ONLY   2'h0
`define CBS_SEQ_EVEN_ONLY  2'h1
`define CBS_SEQ_ODD_EVEN   2'h2
`define CBS_SEQ_EVEN_ODD   2'h3
`define CBS_ODD_MASK       6'h15
`define CBS_EVEN_MASK      6'h2A
`define CBS_TIMER_W        7
`define CBS_CLK_NS         5
`define CBS_SEC_NS         1000000000
`define CBS_SEC_CYC        (`CBS_SEC_NS / `CBS_CLK_NS)
`define CBS_MIN_SEC        60
`define CBS_CHECK_US       2500
`define CBS_CHECK_CYC      ((`CBS_CHECK_US * 1000 + `CBS_CLK_NS - 1) / `CBS_CLK_NS)
`endif

// file: cbs_tick_gen.v
`timescale 1ns/1ps
`include "cbs_defines.vh"
module cbs_tick_gen #(
    parameter SEC_CYC = `CBS_SEC_CYC
) (
    core_clk,
    sys_rst,
    run,
    unit_min,
    tick
);
    input  wire core_clk;
    input  wire sys_rst;
    input  wire run;
    input  wire unit_min;
    output reg  tick;

    reg [31:0] cyc_q;
    reg [5:0]  sec_q;
    wire       sec_end;

    assign sec_end = (cyc_q == SEC_CYC - 1);

    // shared time base for the cell timers and the duty timer
    always @(posedge core_clk) begin
        if (sys_rst) begin
            cyc_q <= 32'h0;
            sec_q <= 6'h0;
            tick  <= 1'b0;
        end else if (!run) begin
            tick <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (sec_end) begin
                cyc_q <= 32'h0;
                if (!unit_min) begin
                    tick <= 1'b1;
                end else if (sec_q == `CBS_MIN_SEC - 1) begin
                    sec_q <= 6'h0;
                    tick  <= 1'b1;
                end else begin
                    sec_q <= sec_q + 6'h1;
                end
            end else begin
                cyc_q <= cyc_q + 32'h1;
            end
        end
    end
endmodule

// file: cbs_sequencer.v
`timescale 1ns/1ps
`include "cbs_defines.vh"
module cbs_sequencer #(
    parameter SEC_CYC   = `CBS_SEC_CYC,
    parameter CHECK_CYC = `CBS_CHECK_CYC
) (
    core_clk,
    sys_rst,
    start_balancing,
    cell1_timer,
    cell2_timer,
    cell3_timer,
    cell4_timer,
    cell5_timer,
    cell6_timer,
    time_unit_min,
    bank_order_select,
    duty,
    abort_on_fault,
    cell_voltage_done,
    fault_unmasked,
    balancing_hold,
    manual_cell_select,
    manual_switch_apply,
    switch_check_enable,
    switch_check_raw,
    low_cell_raw,
    open_wire_ctrl_in,
    switch_state,
    cell_done,
    aborted_by_fault,
    balancing_running,
    balancing_complete,
    balancing_paused,
    switch_check_flags,
    low_cell_flags,
    open_wire_sink_en,
    open_wire_source_en
);
    input  wire       core_clk;
    input  wire       sys_rst;
    input  wire       start_balancing;
    input  wire [6:0] cell1_timer;
    input  wire [6:0] cell2_timer;
    input  wire [6:0] cell3_timer;
    input  wire [6:0] cell4_timer;
    input  wire [6:0] cell5_timer;
    input  wire [6:0] cell6_timer;
    input  wire       time_unit_min;
    input  wire [1:0] bank_order_select;
    input  wire [6:0] duty;
    input  wire       abort_on_fault;
    input  wire [5:0] cell_voltage_done;
    input  wire       fault_unmasked;
    input  wire       balancing_hold;
    input  wire [5:0] manual_cell_select;
    input  wire       manual_switch_apply;
    input  wire [5:0] switch_check_enable;
    input  wire [5:0] switch_check_raw;
    input  wire [5:0] low_cell_raw;
    input  wire [6:0] open_wire_ctrl_in;
    output reg  [5:0] switch_state;
    output reg  [5:0] cell_done;
    output reg        aborted_by_fault;
    output reg        balancing_running;
    output reg        balancing_complete;
    output reg        balancing_paused;
    output reg  [5:0] switch_check_flags;
    output reg  [5:0] low_cell_flags;
    output reg  [5:0] open_wire_sink_en;
    output reg        open_wire_source_en;

    localparam ST_IDLE  = 2'h0;
    localparam ST_FIRST = 2'h1;
    localparam ST_SEC   = 2'h2;
    localparam ST_DUTY  = 2'h3;

    reg [1:0]  state_q;
    reg [41:0] timer_q;
    reg [5:0]  bank_sel_q;
    reg [1:0]  order_q;
    reg [6:0]  duty_q;
    reg [6:0]  duty_cnt_q;
    reg        unit_q;
    reg        fstop_q;
    reg        on_odd_q;
    reg        apply_q;
    reg        manual_on_q;
    reg [5:0]  manual_sel_q;
    reg [5:0]  chk_en_q;
    reg [31:0] chk_cnt_q;
    wire       tick;
    wire       run_timers;
    wire [5:0] active_bank;
    wire [5:0] odd_left;
    wire [5:0] even_left;
    integer    i;

    function adjacent;
        input [5:0] sel;
        begin
            adjacent = |(sel[4:0] & sel[5:1]);
        end
    endfunction

    function [5:0] zero_cells;
        input [41:0] t;
        integer k;
        begin
            zero_cells = 6'h0;
            for (k = 0; k < 6; k = k + 1) begin
                zero_cells[k] = (t[k*7 +: 7] == 7'h0);
            end
        end
    endfunction

    assign run_timers = (state_q != ST_IDLE) && !balancing_hold;
    assign odd_left   = `CBS_ODD_MASK & bank_sel_q & ~cell_done;
    assign even_left  = `CBS_EVEN_MASK & bank_sel_q & ~cell_done;
    assign active_bank = on_odd_q ? `CBS_ODD_MASK : `CBS_EVEN_MASK;

    cbs_tick_gen #(
        .SEC_CYC (SEC_CYC)
    ) u_tick (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .run      (run_timers),
        .unit_min (unit_q),
        .tick     (tick)
    );

    always @(posedge core_clk) begin
        if (sys_rst) begin
            state_q            <= ST_IDLE;
            timer_q            <= 42'h0;
            bank_sel_q         <= 6'h0;
            order_q            <= 2'h0;
            duty_q             <= 7'h0;
            duty_cnt_q         <= 7'h0;
            unit_q             <= 1'b0;
            fstop_q            <= 1'b0;
            on_odd_q           <= 1'b1;
            cell_done          <= 6'h0;
            aborted_by_fault   <= 1'b0;
            balancing_running  <= 1'b0;
            balancing_complete <= 1'b0;
        end else if (start_balancing) begin
            timer_q <= {cell6_timer, cell5_timer, cell4_timer,
                        cell3_timer, cell2_timer, cell1_timer};
            order_q <= bank_order_select;
            duty_q  <= duty;
            unit_q  <= time_unit_min;
            fstop_q <= abort_on_fault;
            case (bank_order_select)
                `CBS_SEQ_ODD_ONLY:  bank_sel_q <= `CBS_ODD_MASK;
                `CBS_SEQ_EVEN_ONLY: bank_sel_q <= `CBS_EVEN_MASK;
                default:            bank_sel_q <= 6'h3F;
            endcase
            on_odd_q <= (bank_order_select != `CBS_SEQ_EVEN_ONLY) &&
                        (bank_order_select != `CBS_SEQ_EVEN_ODD);
            duty_cnt_q <= 7'h0;
            cell_done  <= 6'h0;
            aborted_by_fault   <= 1'b0;
            balancing_complete <= 1'b0;
            balancing_running  <= 1'b1;
            state_q <= (duty != 7'h0 && bank_order_select[1]) ?
                       ST_DUTY : ST_FIRST;
        end else if (run_timers) begin
            // fault seen only when not held
            if (fstop_q && fault_unmasked) begin
                aborted_by_fault   <= 1'b1;
                balancing_complete <= 1'b1;
                balancing_running  <= 1'b0;
                state_q            <= ST_IDLE;
            end else begin
                cell_done <= cell_done |
                             (bank_sel_q & zero_cells(timer_q));
                for (i = 0; i < 6; i = i + 1) begin
                    if (active_bank[i] && bank_sel_q[i] && !cell_done[i]) begin
                        if (cell_voltage_done[i] ||
                            (tick && timer_q[i*7 +: 7] == 7'h1)) begin
                            cell_done[i] <= 1'b1;
                        end
                        if (tick && timer_q[i*7 +: 7] != 7'h0) begin
                            timer_q[i*7 +: 7] <= timer_q[i*7 +: 7] - 7'h1;
                        end
                    end
                end
                case (state_q)
                    ST_FIRST: begin
                        if ((on_odd_q ? odd_left : even_left) == 6'h0) begin
                            if (order_q[1]) begin
                                on_odd_q <= !on_odd_q;
                                state_q  <= ST_SEC;
                            end else begin
                                state_q            <= ST_IDLE;
                                balancing_complete <= 1'b1;
                                balancing_running  <= 1'b0;
                            end
                        end
                    end
                    ST_SEC: begin
                        if ((on_odd_q ? odd_left : even_left) == 6'h0) begin
                            state_q            <= ST_IDLE;
                            balancing_complete <= 1'b1;
                            balancing_running  <= 1'b0;
                        end
                    end
                    ST_DUTY: begin
                        if ((odd_left | even_left) == 6'h0) begin
                            state_q            <= ST_IDLE;
                            balancing_complete <= 1'b1;
                            balancing_running  <= 1'b0;
                        end else if ((on_odd_q ? odd_left : even_left)
                                     == 6'h0) begin
                            on_odd_q   <= !on_odd_q;
                            duty_cnt_q <= 7'h0;
                        end else if (tick) begin
                            if (duty_cnt_q == duty_q - 7'h1) begin
                                duty_cnt_q <= 7'h0;
                                if ((on_odd_q ? even_left : odd_left)
                                    != 6'h0) begin
                                    on_odd_q <= !on_odd_q;
                                end
                            end else begin
                                duty_cnt_q <= duty_cnt_q + 7'h1;
                            end
                        end
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end

    // manual switch control
    always @(posedge core_clk) begin
        if (sys_rst) begin
            apply_q      <= 1'b0;
            manual_on_q  <= 1'b0;
            manual_sel_q <= 6'h0;
        end else begin
            apply_q <= manual_switch_apply;
            if (!manual_switch_apply) begin
                manual_on_q <= 1'b0;
            end else if (!apply_q &&
                         (!balancing_running || balancing_hold)) begin
                manual_on_q  <= !adjacent(manual_cell_select);
                manual_sel_q <= manual_cell_select;
            end
            if (start_balancing) begin
                manual_on_q <= 1'b0;
            end
        end
    end

    // switch outputs and status
    always @(posedge core_clk) begin
        if (sys_rst) begin
            switch_state     <= 6'h0;
            balancing_paused <= 1'b0;
        end else begin
            balancing_paused <= balancing_hold && balancing_running;
            if (run_timers && !start_balancing &&
                !(fstop_q && fault_unmasked)) begin
                switch_state <= active_bank & bank_sel_q & ~cell_done &
                                ~zero_cells(timer_q) &
                                ~cell_voltage_done;
            end else if (manual_on_q) begin
                switch_state <= manual_sel_q;
            end else begin
                switch_state <= 6'h0;
            end
        end
    end

    // switch check and open-wire diagnostics
    always @(posedge core_clk) begin
        if (sys_rst) begin
            chk_en_q            <= 6'h0;
            chk_cnt_q           <= 32'h0;
            switch_check_flags  <= 6'h0;
            low_cell_flags      <= 6'h0;
            open_wire_sink_en   <= 6'h0;
            open_wire_source_en <= 1'b0;
        end else begin
            chk_en_q <= switch_check_enable;
            if (switch_check_enable != chk_en_q) begin
                chk_cnt_q <= 32'h0;
            end else if (chk_cnt_q != CHECK_CYC) begin
                chk_cnt_q <= chk_cnt_q + 32'h1;
            end
            // flags held clear until the comparators settle
            if (chk_cnt_q == CHECK_CYC) begin
                switch_check_flags <= switch_check_enable & switch_check_raw;
            end else begin
                switch_check_flags <= 6'h0;
            end
            low_cell_flags     <= switch_check_enable & low_cell_raw;
            open_wire_sink_en   <= open_wire_ctrl_in[6:1];
            open_wire_source_en <= open_wire_ctrl_in[0];
        end
    end
endmodule

// file: cbs_cell_model.sv
`timescale 1ns/1ps
module cbs_cell_model #(
    parameter DRAIN = 12
) (
    input  wire       core_clk,
    input  wire       drain_en,
    input  wire [5:0] switch_state,
    output reg  [5:0] cell_voltage_done = 6'h00,
    output wire [5:0] switch_check_raw
);
    reg [7:0] drain_q [0:5];
    integer   k;
    // a closed switch drains its cell toward the done level
    always @(posedge core_clk) begin
        for (k = 0; k < 6; k = k + 1) begin
            if (!drain_en)
                drain_q[k] <= 8'h00;
            else if (switch_state[k])
                drain_q[k] <= drain_q[k] + 8'h01;
            cell_voltage_done[k] <= drain_en && drain_q[k] >= DRAIN;
        end
    end
    // open switch leaves the pin above a third of the cell
    assign switch_check_raw = ~switch_state;
endmodule

// file: cbs_sequencer_props.sv
`timescale 1ns/1ps
module cbs_sequencer_props #(
    parameter SEC_CYC   = 4,
    parameter CHECK_CYC = 8
) (
    input wire       core_clk,
    input wire       sys_rst,
    input wire       start_balancing,
    input wire [6:0] cell1_timer,
    input wire [1:0] bank_order_select,
    input wire       abort_on_fault,
    input wire       fault_unmasked,
    input wire       balancing_hold,
    input wire       manual_switch_apply,
    input wire [5:0] switch_state,
    input wire [5:0] cell_done,
    input wire       aborted_by_fault,
    input wire       balancing_running,
    input wire       balancing_complete,
    input wire       balancing_paused
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    sequence s_zero_cell1;
        start_balancing && cell1_timer == 7'h00 && bank_order_select != 2'h1
            ##1 !start_balancing;
    endsequence
    sequence s_odd_only;
        start_balancing && bank_order_select == 2'h0 ##1 !start_balancing;
    endsequence
    sequence s_held;
        (balancing_running && balancing_hold && !manual_switch_apply) [*3];
    endsequence
    chk_run_start:
        assert property (start_balancing |=> balancing_running)
        else $error("running flag missing after start");
    chk_run_end:
        assert property ($fell(balancing_running) |->
            balancing_complete || aborted_by_fault)
        else $error("running dropped without complete");
    chk_done_kept:
        assert property (!start_balancing |=>
            (cell_done & $past(cell_done)) == $past(cell_done))
        else $error("done bit cleared without start");
    chk_zero_done:
        assert property (s_zero_cell1 |=> cell_done[0])
        else $error("zero timer cell not done");
    chk_bank_clear:
        assert property (s_odd_only |=> (cell_done & 6'h2A) == 6'h00)
        else $error("even done bits not cleared");
    chk_no_adjacent:
        assert property ((switch_state & {1'b0, switch_state[5:1]}) == 6'h00)
        else $error("adjacent switches on");
    chk_hold_flag:
        assert property (balancing_running && balancing_hold |->
            ##[1:2] balancing_paused)
        else $error("paused flag missing");
    chk_hold_off:
        assert property (s_held |-> switch_state == 6'h00)
        else $error("switch on while held");
    chk_fault_held:
        assert property (balancing_hold && balancing_paused && !start_balancing
            |=> $stable(aborted_by_fault))
        else $error("abort changed while held");
    chk_abort_stop:
        assert property (abort_on_fault && fault_unmasked && balancing_running
            && !balancing_hold && !balancing_paused
            |-> ##[1:3] aborted_by_fault && switch_state == 6'h00)
        else $error("fault did not stop balancing");
endmodule
bind cbs_sequencer cbs_sequencer_props #(
    .SEC_CYC(SEC_CYC), .CHECK_CYC(CHECK_CYC)
) u_props (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .start_balancing(start_balancing), .cell1_timer(cell1_timer),
    .bank_order_select(bank_order_select), .abort_on_fault(abort_on_fault),
    .fault_unmasked(fault_unmasked), .balancing_hold(balancing_hold),
    .manual_switch_apply(manual_switch_apply), .switch_state(switch_state),
    .cell_done(cell_done), .aborted_by_fault(aborted_by_fault),
    .balancing_running(balancing_running),
    .balancing_complete(balancing_complete),
    .balancing_paused(balancing_paused)
);

// file: cbs_tb.sv
`timescale 1ns/1ps
module tb;
    reg         core_clk = 1'b0;
    reg         sys_rst = 1'b1;
    reg         start_balancing = 1'b0;
    reg  [41:0] tmrs = 42'h0;
    reg  [1:0]  order = 2'h0;
    reg  [6:0]  duty = 7'h00;
    reg         abort_on_fault = 1'b0;
    reg         fault_unmasked = 1'b0;
    reg         hold = 1'b0;
    reg  [5:0]  msel = 6'h00;
    reg         mapply = 1'b0;
    reg  [5:0]  chk_en = 6'h00;
    reg  [5:0]  low_raw = 6'h00;
    reg  [6:0]  ow_ctrl = 7'h00;
    reg         drain_en = 1'b0;
    reg         unit = 1'b0;
    reg  [5:0]  sw_seen = 6'h00;
    reg  [1:0]  bank_q = 2'h0;
    reg  [3:0]  n_bank = 4'h0;
    integer     n_fail = 0;
    integer     compares = 0;
    wire [5:0]  vdone, chk_raw, sw, done, chk_flags, low_flags, sink_en;
    wire        aborted, running, complete, paused, src_en;
    cbs_sequencer #(.SEC_CYC(4), .CHECK_CYC(8)) uut (
        .core_clk(core_clk), .sys_rst(sys_rst),
        .start_balancing(start_balancing), .cell1_timer(tmrs[6:0]),
        .cell2_timer(tmrs[13:7]), .cell3_timer(tmrs[20:14]),
        .cell4_timer(tmrs[27:21]), .cell5_timer(tmrs[34:28]),
        .cell6_timer(tmrs[41:35]), .time_unit_min(unit),
        .bank_order_select(order), .duty(duty),
        .abort_on_fault(abort_on_fault), .cell_voltage_done(vdone),
        .fault_unmasked(fault_unmasked), .balancing_hold(hold),
        .manual_cell_select(msel), .manual_switch_apply(mapply),
        .switch_check_enable(chk_en), .switch_check_raw(chk_raw),
        .low_cell_raw(low_raw), .open_wire_ctrl_in(ow_ctrl),
        .switch_state(sw), .cell_done(done), .aborted_by_fault(aborted),
        .balancing_running(running), .balancing_complete(complete),
        .balancing_paused(paused), .switch_check_flags(chk_flags),
        .low_cell_flags(low_flags), .open_wire_sink_en(sink_en),
        .open_wire_source_en(src_en)
    );
    cbs_cell_model u_cells (.core_clk(core_clk), .drain_en(drain_en),
        .switch_state(sw), .cell_voltage_done(vdone),
        .switch_check_raw(chk_raw));
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    // tracks every switch seen and each change of active bank
    always @(posedge core_clk) begin
        if (start_balancing) begin
            sw_seen <= 6'h00;
            bank_q <= 2'h0;
            n_bank <= 4'h0;
        end else begin
            sw_seen <= sw_seen | sw;
            if (|(sw & 6'h15) && bank_q != 2'h1) begin
                bank_q <= 2'h1;
                n_bank <= n_bank + 4'h1;
            end else if (|(sw & 6'h2A) && bank_q != 2'h2) begin
                bank_q <= 2'h2;
                n_bank <= n_bank + 4'h1;
            end
        end
    end
    task chk(input [5:0] got, input [5:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task final_report;
        begin
            $display("compares=%0d n_fail=%0d", compares, n_fail);
            if (n_fail == 0 && compares > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    task cyc(input integer n);
        begin
            repeat (n) @(posedge core_clk);
            #1;
        end
    endtask
    task wait_end(input integer lim);
        integer k;
        begin
            k = 0;
            @(posedge core_clk);
            while (k < lim && complete !== 1'b1) begin
                @(posedge core_clk);
                k = k + 1;
            end
            #1;
            if (k == lim) begin
                n_fail = n_fail + 1;
                final_report;
            end
        end
    endtask
    function [41:0] rep(input [6:0] a, input [6:0] b);
        rep = {b, a, b, a, b, a};
    endfunction
    task go(input [1:0] o, input [6:0] d, input [41:0] t);
        begin
            @(posedge core_clk);
            order <= o;
            duty <= d;
            tmrs <= t;
            start_balancing <= 1'b1;
            @(posedge core_clk);
            start_balancing <= 1'b0;
        end
    endtask
    task t_zero;
        begin
            go(2'h0, 7'h00, {7'h05, 7'h03, 7'h05, 7'h02, 7'h05, 7'h00});
            cyc(2);
            chk(done, 6'h01);
            wait_end(300);
            chk(done, 6'h15);
            chk(sw_seen, 6'h14);
            chk({4'h0, running, complete}, 6'h01);
            $display("t_zero end");
        end
    endtask
    task t_two;
        begin
            go(2'h2, 7'h00, rep(7'h02, 7'h02));
            tmrs <= 42'h0;
            wait_end(300);
            chk(done, 6'h3F);
            chk(sw_seen, 6'h3F);
            chk({bank_q, n_bank}, 6'h22);
            $display("t_two end");
        end
    endtask
    task t_duty;
        begin
            go(2'h3, 7'h01, rep(7'h04, 7'h02));
            wait_end(400);
            chk(done, 6'h3F);
            chk({bank_q, n_bank}, 6'h14);
            $display("t_duty end");
        end
    endtask
    task t_volt;
        begin
            drain_en <= 1'b1;
            go(2'h0, 7'h00, rep(7'h64, 7'h64));
            wait_end(150);
            chk(done, 6'h15);
            drain_en <= 1'b0;
            $display("t_volt end");
        end
    endtask
    task t_hold;
        begin
            abort_on_fault <= 1'b1;
            go(2'h0, 7'h00, rep(7'h32, 7'h32));
            msel <= 6'h02;
            mapply <= 1'b1;
            cyc(4);
            chk(sw, 6'h15);
            @(posedge core_clk);
            mapply <= 1'b0;
            hold <= 1'b1;
            chk_en <= 6'h0F;
            low_raw <= 6'h21;
            ow_ctrl <= 7'h41;
            cyc(5);
            chk(chk_flags, 6'h00);
            cyc(5);
            chk({paused, running, aborted, src_en, 2'h0}, 6'h34);
            chk(sw, 6'h00);
            chk(chk_flags, 6'h0F);
            chk(low_flags, 6'h01);
            chk(sink_en, 6'h20);
            @(posedge core_clk);
            fault_unmasked <= 1'b1;
            msel <= 6'h05;
            mapply <= 1'b1;
            cyc(4);
            chk({5'h00, aborted}, 6'h00);
            chk(sw, 6'h05);
            @(posedge core_clk);
            mapply <= 1'b0;
            msel <= 6'h06;
            @(posedge core_clk);
            mapply <= 1'b1;
            cyc(4);
            chk(sw, 6'h00);
            @(posedge core_clk);
            mapply <= 1'b0;
            hold <= 1'b0;
            cyc(5);
            chk({4'h0, aborted, |sw}, 6'h02);
            @(posedge core_clk);
            fault_unmasked <= 1'b0;
            abort_on_fault <= 1'b0;
            $display("t_hold end");
        end
    endtask
    task t_abort;
        begin
            @(posedge core_clk);
            abort_on_fault <= 1'b1;
            go(2'h0, 7'h00, rep(7'h32, 7'h32));
            cyc(4);
            @(posedge core_clk);
            fault_unmasked <= 1'b1;
            cyc(3);
            chk({aborted, complete, running, 3'h0}, 6'h30);
            chk(sw, 6'h00);
            @(posedge core_clk);
            fault_unmasked <= 1'b0;
            abort_on_fault <= 1'b0;
            go(2'h1, 7'h00, {7'h32, 7'h32, 7'h00, 7'h32, 7'h32, 7'h32});
            cyc(4);
            chk(done, 6'h08);
            chk(sw, 6'h22);
            @(posedge core_clk);
            sys_rst <= 1'b1;
            cyc(2);
            @(posedge core_clk);
            sys_rst <= 1'b0;
            cyc(1);
            chk({running, complete, aborted, paused, 2'h0}, 6'h00);
            chk(sw | done, 6'h00);
            $display("t_abort end");
        end
    endtask
    task t_unit;
        begin
            @(posedge core_clk);
            unit <= 1'b1;
            go(2'h0, 7'h00, {35'h0, 7'h01});
            cyc(200);
            chk(done, 6'h14);
            wait_end(100);
            chk(done, 6'h15);
            @(posedge core_clk);
            unit <= 1'b0;
            $display("t_unit end");
        end
    endtask
    task t_stop;
        begin
            go(2'h0, 7'h00, rep(7'h32, 7'h32));
            cyc(6);
            go(2'h0, 7'h00, 42'h0);
            wait_end(20);
            chk(done, 6'h15);
            $display("t_stop end");
        end
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        cyc(1);
        chk({running, complete, paused, aborted, 2'h0}, 6'h00);
        t_zero;
        t_two;
        t_duty;
        t_volt;
        t_hold;
        t_abort;
        t_unit;
        t_stop;
        final_report;
    end
endmodule
